// >>> hw/reset_cause_status.sv
// Reset cause register with watchdog service decoding and APB access.
`timescale 1ns/10ps
`default_nettype none
module reset_cause_status
  import reset_cause_pkg::*;
#(
  parameter int CNT_W = 20
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             power_on_cause,
  input  wire logic             pin_cause,
  input  wire logic             wdog_cause,
  input  wire logic             opcode_cause,
  input  wire logic             addr_cause,
  input  wire logic             clock_cause,
  input  wire logic             volt_cause,
  input  wire logic             debug_forced_reset_bit,
  input  wire logic [1:0]       watchdog_timeout_select,
  input  wire logic             watchdog_window_mode,
  input  wire logic [CNT_W-1:0] wdog_period,
  output logic                  wdog_clear,
  output logic                  wdog_reset_req,
  output logic                  irq
);
  logic [7:0] src_raw;
  logic [7:0] src_sync;
  logic       dbg_sync;
  assign src_raw = {power_on_cause, pin_cause, wdog_cause, opcode_cause,
                    addr_cause, clock_cause, volt_cause, 1'b0};
  sync_2ff #(.W(8)) u_src (.pclk(pclk), .presetn(presetn), .d(src_raw), .q(src_sync));
  sync_2ff #(.W(1)) u_dbg (.pclk(pclk), .presetn(presetn), .d(debug_forced_reset_bit), .q(dbg_sync));

  logic [7:0]       cause_reg, cause_next;
  logic             armed_reg, armed_next;
  logic [CNT_W-1:0] count_reg, count_next;
  logic [irq_width-1:0] stat_reg, stat_next, mask_reg, mask_next;
  logic [1:0]       settle_reg, settle_next;
  logic [31:0]      prdata_next;
  logic             clear_next, rst_next, irq_next;
  logic             wr, rd, wr_cause, enabled, early, ev_bad, ev_wd, capture;
  logic [7:0]       wbyte;
  logic [CNT_W+1:0] scaled_cnt, scaled_open;

  assign wr       = psel && penable && pwrite && pready;
  assign rd       = psel && penable && !pwrite && pready;
  assign wr_cause = wr && (paddr == cause_addr);
  assign wbyte    = pwdata[7:0];
  assign enabled  = (watchdog_timeout_select != sel_off);
  assign scaled_cnt  = {2'b00, count_reg} * (CNT_W+2)'(window_den);
  assign scaled_open = {2'b00, wdog_period} * (CNT_W+2)'(window_num);
  assign early    = watchdog_window_mode && (scaled_cnt < scaled_open);
  assign capture  = (settle_reg == capture_slot);

  always_comb begin
    cause_next  = cause_reg;
    armed_next  = armed_reg;
    count_next  = count_reg;
    stat_next   = stat_reg;
    mask_next   = mask_reg;
    settle_next = (settle_reg == settle_done) ? settle_reg : settle_reg + 2'h1;
    clear_next  = 1'b0;
    rst_next    = 1'b0;
    ev_bad      = 1'b0;
    ev_wd       = 1'b0;
    prdata_next = 32'h0000_0000;
    // Causes are captured once the synchronisers hold levels sampled after release.
    if (capture) begin
      if (dbg_sync) begin
        cause_next = 8'h00; // [R02]
      end else if (src_sync[power_bit]) begin
        cause_next = cause_reset; // [R05] [R12]
      end else begin
        cause_next = src_sync; // [R06] [R07] [R09] [R10] [R11] [R12]
        cause_next[power_bit] = 1'b0;
        cause_next[wdog_bit] = src_sync[wdog_bit] && enabled; // [R08]
      end
      cause_next[0] = 1'b0; // [R14]
    end
    if (enabled) begin
      count_next = (count_reg >= wdog_period) ? count_reg : count_reg + 1'b1;
      if (count_reg >= wdog_period) begin
        ev_wd = 1'b1;
      end
    end else begin
      count_next = '0;
    end
    if (wr_cause && enabled) begin
      if (early) begin
        ev_bad = 1'b1; // [R13]
      end else if (wbyte == key_first) begin
        armed_next = 1'b1;
      end else if (wbyte == key_second) begin
        if (armed_reg) begin
          clear_next = 1'b1; // [R04]
          count_next = '0;
        end
        armed_next = 1'b0;
      end else begin
        ev_bad = 1'b1; // [R03]
      end
    end
    rst_next = ev_bad || ev_wd; // [R08]
    if (wr && paddr == irq_mask_addr) begin
      mask_next = pwdata[irq_width-1:0];
    end
    if (wr && paddr == irq_stat_addr) begin
      stat_next = stat_reg & ~pwdata[irq_width-1:0];
    end
    if (ev_wd) begin
      stat_next[irq_watchdog] = 1'b1;
    end
    if (ev_bad) begin
      stat_next[irq_bad_write] = 1'b1;
    end
    irq_next = |(stat_next & mask_next);
    if (psel && !penable && !pwrite) begin
      case (paddr)
        cause_addr:    prdata_next = {24'h000000, cause_reg}; // [R01]
        irq_stat_addr: prdata_next = {{(32-irq_width){1'b0}}, stat_reg};
        irq_mask_addr: prdata_next = {{(32-irq_width){1'b0}}, mask_reg};
        ctrl_addr:     prdata_next = {29'h0, watchdog_window_mode, watchdog_timeout_select};
        count_addr:    prdata_next = {{(32-CNT_W){1'b0}}, count_reg};
        default:       prdata_next = 32'h0000_0000;
      endcase
    end else if (!(psel && penable)) begin
      prdata_next = 32'h0000_0000;
    end else begin
      prdata_next = prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_reg      <= 8'h00;
      armed_reg      <= 1'b0;
      count_reg      <= '0;
      stat_reg       <= '0;
      mask_reg       <= '0;
      settle_reg     <= 2'h0;
      prdata         <= 32'h0000_0000;
      pready         <= 1'b0;
      pslverr        <= 1'b0;
      wdog_clear     <= 1'b0;
      wdog_reset_req <= 1'b0;
      irq            <= 1'b0;
    end else begin
      cause_reg      <= cause_next;
      armed_reg      <= armed_next;
      count_reg      <= count_next;
      stat_reg       <= stat_next;
      mask_reg       <= mask_next;
      settle_reg     <= settle_next;
      prdata         <= prdata_next;
      pready         <= psel && !penable;
      pslverr        <= 1'b0;
      wdog_clear     <= clear_next;
      wdog_reset_req <= rst_next;
      irq            <= irq_next;
    end
  end

  property p_readonly;
    @(posedge pclk) disable iff (!presetn)
      ((settle_reg == settle_done) && ($past(settle_reg) == settle_done)) |-> $stable(cause_reg);
  endproperty
  a_readonly: assert property (p_readonly) else $error("cause changed after capture"); // [R01]

  property p_debug;
    @(posedge pclk) disable iff (!presetn)
      (capture && dbg_sync) |=> (cause_reg == 8'h00);
  endproperty
  a_debug: assert property (p_debug) else $error("debug reset left a flag set"); // [R02]

  property p_bad;
    @(posedge pclk) disable iff (!presetn)
      (wr_cause && enabled && wbyte != key_first && wbyte != key_second) |=> wdog_reset_req;
  endproperty
  a_bad: assert property (p_bad) else $error("bad write gave no reset"); // [R03]

  property p_service;
    @(posedge pclk) disable iff (!presetn)
      (wdog_clear) |-> $stable(cause_reg) ##0 (count_reg == '0);
  endproperty
  a_service: assert property (p_service) else $error("service did not clear timer"); // [R04]

  property p_power;
    @(posedge pclk) disable iff (!presetn)
      (capture && !dbg_sync && src_sync[power_bit]) |=> (cause_reg == cause_reset);
  endproperty
  a_power: assert property (p_power) else $error("power-on flags wrong"); // [R05]

  property p_pin;
    @(posedge pclk) disable iff (!presetn)
      (capture && !dbg_sync && !src_sync[power_bit]) |=> (cause_reg[pin_bit] == $past(src_sync[pin_bit]));
  endproperty
  a_pin: assert property (p_pin) else $error("pin flag wrong"); // [R07]

  property p_noreset_off;
    @(posedge pclk) disable iff (!presetn)
      (!enabled) [*2] |-> !wdog_reset_req;
  endproperty
  a_noreset_off: assert property (p_noreset_off) else $error("reset while watchdog off"); // [R08]

  property p_window;
    @(posedge pclk) disable iff (!presetn)
      (wr_cause && enabled && early) |=> wdog_reset_req && !wdog_clear;
  endproperty
  a_window: assert property (p_window) else $error("early write not punished"); // [R13]

  property p_bit0;
    @(posedge pclk) disable iff (!presetn) cause_reg[0] == 1'b0;
  endproperty
  a_bit0: assert property (p_bit0) else $error("bit 0 set"); // [R14]

  property p_key_clear;
    @(posedge pclk) disable iff (!presetn)
      (wr_cause && enabled && !early && (wbyte == key_second) && armed_reg) |=> wdog_clear;
  endproperty
  a_key_clear: assert property (p_key_clear) else $error("armed service gave no clear"); // [R04]

  property p_no_clear;
    @(posedge pclk) disable iff (!presetn)
      (wr_cause && (wbyte == key_second) && !armed_reg) |=> !wdog_clear;
  endproperty
  a_no_clear: assert property (p_no_clear) else $error("unarmed write cleared timer"); // [R04]

  property p_sources;
    @(posedge pclk) disable iff (!presetn)
      (capture && !dbg_sync && !src_sync[power_bit]) |=>
        (cause_reg[opcode_bit] == $past(src_sync[opcode_bit])) &&
        (cause_reg[addr_bit] == $past(src_sync[addr_bit])) &&
        (cause_reg[clock_bit] == $past(src_sync[clock_bit])) &&
        (cause_reg[volt_bit] == $past(src_sync[volt_bit]));
  endproperty
  a_sources: assert property (p_sources) else $error("source flags wrong"); // [R06] [R09] [R10] [R11] [R12]

  property p_wdog_flag;
    @(posedge pclk) disable iff (!presetn)
      (capture && !dbg_sync && !src_sync[power_bit] && !enabled) |=> !cause_reg[wdog_bit];
  endproperty
  a_wdog_flag: assert property (p_wdog_flag) else $error("watchdog flag set while off"); // [R08]

  property p_timeout;
    @(posedge pclk) disable iff (!presetn)
      (enabled && (count_reg >= wdog_period)) |=> wdog_reset_req;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout gave no reset"); // [R08]

  property p_settle;
    @(posedge pclk) disable iff (!presetn)
      (settle_reg == settle_done) |=> (settle_reg == settle_done);
  endproperty
  a_settle: assert property (p_settle) else $error("capture counter restarted"); // [R06]

  property p_read_cause;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && (paddr == cause_addr)) |=> (prdata == {24'h000000, $past(cause_reg)});
  endproperty
  a_read_cause: assert property (p_read_cause) else $error("cause read data wrong"); // [R01]

  property p_idle_data;
    @(posedge pclk) disable iff (!presetn)
      (!psel) |=> (prdata == 32'h0000_0000);
  endproperty
  a_idle_data: assert property (p_idle_data) else $error("read data not zero when idle");

  property p_ready;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready in access cycle");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
      irq == (|(stat_reg & mask_reg));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");

  property p_stat_set;
    @(posedge pclk) disable iff (!presetn)
      ev_wd |=> stat_reg[irq_watchdog];
  endproperty
  a_stat_set: assert property (p_stat_set) else $error("timeout status not set"); // [R08]

  property p_bad_stat;
    @(posedge pclk) disable iff (!presetn)
      ev_bad |=> stat_reg[irq_bad_write];
  endproperty
  a_bad_stat: assert property (p_bad_stat) else $error("bad write status not set"); // [R03]

  c_service: cover property (@(posedge pclk) disable iff (!presetn) wdog_clear);
  c_bad: cover property (@(posedge pclk) disable iff (!presetn) ev_bad);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
  c_early: cover property (@(posedge pclk) disable iff (!presetn) wr_cause && early);
  c_timeout: cover property (@(posedge pclk) disable iff (!presetn) ev_wd);
endmodule
`default_nettype wire

// >>> hw/reset_cause_pkg.sv
// Constants for the reset cause and watchdog service block.
// Overview of operation
// (R01) Cause flags are read-only to software.
// (R02) Debug forced reset leaves all flags clear.
// (R03) Other write values force watchdog reset.
// (R04) 0x55 then 0xAA clears watchdog timer.
// (R05) Power-on sets bits 7 and 1 only.
// (R06) Active sources set flags at reset entry; the code captures levels sampled after release.
// (R07) Bit 6 marks external reset pin.
// (R08) Bit 5 marks watchdog timeout; select 0 blocks.
// (R09) Bit 4 marks illegal opcode reset.
// (R10) Bit 3 marks illegal address reset.
// (R11) Bit 2 marks reference clock loss.
// (R12) Bit 1 marks undervoltage or power-on.
// (R13) Window mode: service only in last quarter.
// (R14) Bit 0 always reads zero.
package reset_cause_pkg;
  localparam logic [11:0] cause_addr     = 12'h000;
  localparam logic [11:0] irq_stat_addr  = 12'h004;
  localparam logic [11:0] irq_mask_addr  = 12'h008;
  localparam logic [11:0] ctrl_addr      = 12'h00C;
  localparam logic [11:0] count_addr     = 12'h010;
  localparam logic [7:0]  key_first      = 8'h55;
  localparam logic [7:0]  key_second     = 8'hAA;
  localparam int          power_bit      = 7;
  localparam int          pin_bit        = 6;
  localparam int          wdog_bit       = 5;
  localparam int          opcode_bit     = 4;
  localparam int          addr_bit       = 3;
  localparam int          clock_bit      = 2;
  localparam int          volt_bit       = 1;
  localparam logic [7:0]  cause_reset    = 8'h82;
  localparam int          irq_watchdog   = 0;
  localparam int          irq_bad_write  = 1;
  localparam int          irq_width      = 2;
  localparam logic [1:0]  sel_off        = 2'h0;
  localparam logic [1:0]  capture_slot   = 2'h2;
  localparam logic [1:0]  settle_done    = 2'h3;
  localparam int          window_num     = 3;
  localparam int          window_den     = 4;
endpackage

// >>> hw/sync_2ff.sv
// Two-flip-flop synchroniser for a bus of asynchronous levels.
`timescale 1ns/10ps
`default_nettype none
module sync_2ff #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking testbench for the reset cause register block.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import reset_cause_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, dbg, window, pready, pslverr, clr, req, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0]  causes;
  logic [1:0]  sel;
  logic [19:0] period;
  int          err_count, checked, n_clr, n_req, k, m;

  reset_cause_status #(.CNT_W(20)) u_reset_cause_status (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_on_cause(causes[6]), .pin_cause(causes[5]), .wdog_cause(causes[4]),
    .opcode_cause(causes[3]), .addr_cause(causes[2]), .clock_cause(causes[1]),
    .volt_cause(causes[0]), .debug_forced_reset_bit(dbg), .watchdog_timeout_select(sel),
    .watchdog_window_mode(window), .wdog_period(period), .wdog_clear(clr),
    .wdog_reset_req(req), .irq(irq)
  );

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Counts watchdog pulses in mid-cycle, away from the launching edge.
  always @(negedge pclk) begin
    if (clr === 1'b1) n_clr++;
    if (req === 1'b1) n_req++;
  end

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) check("pready", 32'h0, 32'h1);
    rd = prdata;
    check("pslverr", 32'(pslverr), 32'h0);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task do_reset(input logic [6:0] c, input logic d);
    @(posedge pclk);
    causes  <= c;
    dbg     <= d;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    causes <= 7'h00;
    dbg    <= 1'b0;
  endtask

  task t_causes;
    for (k = 0; k < 7; k++) begin
      do_reset(7'h01 << k, 1'b0);
      apb(1'b0, cause_addr, 32'h0);
      check("cause single", rd, (k == 6) ? 32'h82 : (32'h1 << (k + 1)));
    end
    do_reset(7'h7F, 1'b0);
    apb(1'b0, cause_addr, 32'h0);
    check("cause power on", rd, 32'h82);
    do_reset(7'h28, 1'b0);
    apb(1'b0, cause_addr, 32'h0);
    check("cause two sources", rd, 32'h50);
    do_reset(7'h20, 1'b1);
    apb(1'b0, cause_addr, 32'h0);
    check("cause debug", rd, 32'h0);
    sel <= sel_off;
    do_reset(7'h10, 1'b0);
    apb(1'b0, cause_addr, 32'h0);
    check("cause wdog off", rd, 32'h0);
    sel <= 2'h1;
  endtask

  task t_service;
    do_reset(7'h20, 1'b0);
    sel <= sel_off;
    k = n_req;
    apb(1'b1, cause_addr, 32'hFF);
    repeat (4) @(posedge pclk);
    check("req while off", 32'(n_req - k), 32'h0);
    sel <= 2'h1;
    k = n_clr;
    apb(1'b1, cause_addr, 32'(key_first));
    apb(1'b1, cause_addr, 32'(key_second));
    repeat (4) @(posedge pclk);
    check("service clear", 32'(n_clr - k), 32'h1);
    apb(1'b0, cause_addr, 32'h0);
    check("cause kept", rd, 32'h40);
    k = n_req;
    apb(1'b1, cause_addr, 32'h12);
    repeat (4) @(posedge pclk);
    check("bad write req", 32'(n_req > k), 32'h1);
    apb(1'b0, cause_addr, 32'h0);
    check("cause after write", rd, 32'h40);
    k = n_clr;
    apb(1'b1, cause_addr, 32'(key_second));
    repeat (2) @(posedge pclk);
    check("unarmed no clear", 32'(n_clr - k), 32'h0);
  endtask

  task t_irq;
    apb(1'b0, irq_stat_addr, 32'h0);
    check("irq status", rd, 32'h2);
    check("irq masked", 32'(irq), 32'h0);
    apb(1'b1, irq_mask_addr, 32'h2);
    repeat (2) @(negedge pclk);
    check("irq raised", 32'(irq), 32'h1);
    apb(1'b1, irq_stat_addr, 32'h2);
    repeat (2) @(negedge pclk);
    check("irq cleared", 32'(irq), 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    check("unmapped read", rd, 32'h0);
    apb(1'b0, ctrl_addr, 32'h0);
    check("ctrl read", rd, 32'h1);
  endtask

  task t_window;
    window <= 1'b1;
    period <= 20'd80;
    do_reset(7'h00, 1'b0);
    k = n_req;
    apb(1'b1, cause_addr, 32'(key_first));
    repeat (4) @(posedge pclk);
    check("early write req", 32'(n_req > k), 32'h1);
    do_reset(7'h00, 1'b0);
    repeat (60) @(posedge pclk);
    k = n_req;
    m = n_clr;
    apb(1'b1, cause_addr, 32'(key_first));
    apb(1'b1, cause_addr, 32'(key_second));
    repeat (3) @(posedge pclk);
    check("late service clear", 32'(n_clr - m), 32'h1);
    check("late service no req", 32'(n_req - k), 32'h0);
    window <= 1'b0;
    period <= 20'd40;
    do_reset(7'h00, 1'b0);
    k = n_req;
    repeat (50) @(posedge pclk);
    check("timeout req", 32'(n_req > k), 32'h1);
    apb(1'b0, irq_stat_addr, 32'h0);
    check("timeout status", rd, 32'h1);
    period <= 20'd1000;
  endtask

  task results;
    $display("Comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge pclk);
    err_count++;
    results();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    causes = 7'h00;
    dbg = 1'b0;
    window = 1'b0;
    sel = 2'h1;
    period = 20'd1000;
    do_reset(7'h00, 1'b0);
    t_causes();
    t_service();
    t_irq();
    t_window();
    results();
  end
endmodule
`default_nettype wire
